// ---- logic/scpr_pkg.sv ----
package scpr_pkg;
  // ------------------------------------------------------------
  // Widths and command pins
  // ------------------------------------------------------------
  localparam int DQ_W = 8;
  localparam int ADDR_W = 14;
  localparam logic [3:0] PINS_MRS = 4'h0;
  localparam logic [3:0] PINS_WRITE = 4'h4;
  localparam logic [3:0] PINS_READ = 4'h5;
  localparam logic [3:0] PINS_NOP = 4'h7;
  localparam logic [2:0] BA_MODE0 = 3'h0;
  localparam logic [2:0] BA_MODE3 = 3'h3;

  // ------------------------------------------------------------
  // Address bit positions
  // ------------------------------------------------------------
  localparam int PAT_EN_BIT = 2;
  localparam int ORDER_BIT = 2;
  localparam int AP_BIT = 10;
  localparam int CHOP_BIT = 12;

  // ------------------------------------------------------------
  // Mode fields, pattern and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] LOC_PREDEF = 2'h0;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [7:0] PATTERN_PREDEF = 8'haa;
  localparam logic [7:0] PATTERN_RFU = 8'h00;
  localparam logic [2:0] BEAT_FIRST = 3'h0;
  localparam logic [2:0] BEAT_UPPER = 3'h4;
  localparam logic [2:0] CHOP_SPAN = 3'h3;
  localparam logic [2:0] BEAT_LAST = 3'h7;
  localparam logic [3:0] LAT_RST = 4'h5;
  localparam logic MIRROR_RST = 1'b0;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_MODE3 = 4'h0;
  localparam logic [3:0] OFS_MODE0 = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  typedef enum logic [2:0] {CMD_NONE, CMD_MRS, CMD_READ, CMD_WRITE, CMD_OTHER} scpr_cmd_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BURST} scpr_state_t;
endpackage : scpr_pkg

// ---- logic/scpr_stream_if.sv ----
`timescale 1ns/1ps
// Beat stream between burst generator, buffer and pin stage
interface scpr_stream_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface : scpr_stream_if

// ---- logic/scpr_cmd_decode.sv ----
`timescale 1ns/1ps
module scpr_cmd_decode (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [2:0] ba_in,
  input wire logic [scpr_pkg::ADDR_W-1:0] addr_in,
  output scpr_pkg::scpr_cmd_t cmd_out,
  output logic [2:0] ba_out,
  output logic [scpr_pkg::ADDR_W-1:0] addr_out
);
  typedef struct packed {
    scpr_pkg::scpr_cmd_t cmd;
    logic [2:0] ba;
    logic [scpr_pkg::ADDR_W-1:0] addr;
  } scpr_dec_t;

  scpr_dec_t s_q;
  scpr_dec_t s_d;

  // Pin code to command class
  function automatic scpr_pkg::scpr_cmd_t classify(input logic [3:0] pins);
    scpr_pkg::scpr_cmd_t c;
    c = scpr_pkg::CMD_OTHER;
    if (pins[3] || pins == scpr_pkg::PINS_NOP)
      c = scpr_pkg::CMD_NONE;
    else if (pins == scpr_pkg::PINS_MRS)
      c = scpr_pkg::CMD_MRS;
    else if (pins == scpr_pkg::PINS_READ)
      c = scpr_pkg::CMD_READ;
    else if (pins == scpr_pkg::PINS_WRITE)
      c = scpr_pkg::CMD_WRITE;
    return c;
  endfunction : classify

  // One register stage, pins taken at every edge
  always_comb
  begin
    s_d.cmd = classify({cs_n_in, ras_n_in, cas_n_in, we_n_in});
    s_d.ba = ba_in;
    s_d.addr = addr_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign cmd_out = s_q.cmd;
  assign ba_out = s_q.ba;
  assign addr_out = s_q.addr;
endmodule : scpr_cmd_decode

// ---- logic/scpr_beat_fifo.sv ----
`timescale 1ns/1ps
module scpr_beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  scpr_stream_if.sink wr_port,
  scpr_stream_if.src rd_port
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } scpr_fifo_t;

  scpr_fifo_t s_q;
  scpr_fifo_t s_d;
  logic push;
  logic pop;

  // Flags straight from the count, so full really stalls the writer
  assign wr_port.ready = (s_q.cnt != CW'(DEPTH));
  assign rd_port.valid = (s_q.cnt != '0);
  assign rd_port.data = s_q.mem[s_q.rp];
  assign push = wr_port.valid && wr_port.ready;
  assign pop = rd_port.valid && rd_port.ready;

  // Pointers wrap at DEPTH, which need not be a power of two
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = wr_port.data;
      s_d.wp = (s_q.wp == PW'(DEPTH - 1)) ? '0 : PW'(s_q.wp + 1'b1);
    end
    if (pop)
      s_d.rp = (s_q.rp == PW'(DEPTH - 1)) ? '0 : PW'(s_q.rp + 1'b1);
    if (push && !pop)
      s_d.cnt = CW'(s_q.cnt + 1'b1);
    else if (pop && !push)
      s_d.cnt = CW'(s_q.cnt - 1'b1);
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  a_fifo_bound: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    s_q.cnt <= CW'(DEPTH)) else $error("buffer count above depth");
endmodule : scpr_beat_fifo

// ---- logic/scpr_top.sv ----
`timescale 1ns/1ps
// Overview of operation
// - MRS to mode three, A2=1 enables
// - Pattern mode reads come from pattern register
// - Location zero predefined, others reserved
// - Pattern is 0,1,0,1 per beat
// - Read with autoprecharge acts as plain read
// - Reset still works in pattern mode
// - A2 clear means normal array operation
// - Pin 0 carries bit, others copy/zero
// - Eight-beat read uses fixed order 0..7
// - Chopped read: A2 picks lower/upper nibble
// - A12 chops per command when enabled
// - All other address bits are ignored
// - Pattern reads use normal read latency
// - Beat 0 is LSB, beat 7 MSB
module scpr_top #(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [2:0] ba_in,
  input wire logic [scpr_pkg::ADDR_W-1:0] addr_in,
  input wire logic dq_ready_in,
  output logic [scpr_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe_n_out,
  output logic dqs_out,
  output logic array_rd_out,
  output logic array_wr_out,
  output logic precharge_out,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic pat_en;
    logic [1:0] loc;
    logic [1:0] bl_mode;
    logic [3:0] lat;
    logic mirror;
    scpr_pkg::scpr_state_t state;
    logic [3:0] lat_cnt;
    logic [2:0] beat;
    logic [2:0] last;
    logic [7:0] served;
    logic [7:0] refused;
    logic [7:0] illegal;
    logic arr_rd;
    logic arr_wr;
    logic pre;
    logic [scpr_pkg::DQ_W-1:0] dq;
    logic dqs;
    logic oe_n;
    logic ack;
    logic [31:0] rdat;
  } scpr_top_t;

  scpr_top_t s_q;
  scpr_top_t s_d;

  scpr_pkg::scpr_cmd_t dec_cmd;
  logic [2:0] dec_ba;
  logic [scpr_pkg::ADDR_W-1:0] dec_addr;
  logic chop;
  logic take;
  logic [2:0] start;
  logic [7:0] pattern;
  logic beat_bit;
  logic wb_req;

  scpr_stream_if #(.WIDTH(scpr_pkg::DQ_W)) gen_if ();
  scpr_stream_if #(.WIDTH(scpr_pkg::DQ_W)) buf_if ();

  // ------------------------------------------------------------
  // Command capture and beat buffer
  // ------------------------------------------------------------
  scpr_cmd_decode u_dec (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .cs_n_in(cs_n_in),
    .ras_n_in(ras_n_in),
    .cas_n_in(cas_n_in),
    .we_n_in(we_n_in),
    .ba_in(ba_in),
    .addr_in(addr_in),
    .cmd_out(dec_cmd),
    .ba_out(dec_ba),
    .addr_out(dec_addr)
  );

  scpr_beat_fifo #(
    .WIDTH(scpr_pkg::DQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .wr_port(gen_if.sink),
    .rd_port(buf_if.src)
  );

  // ------------------------------------------------------------
  // Burst shaping
  // ------------------------------------------------------------
  // Chop from fixed mode, or from A12 only when on-the-fly is set
  assign chop = (s_q.bl_mode == scpr_pkg::BL_FIXED4) ||
                ((s_q.bl_mode == scpr_pkg::BL_OTF) && !dec_addr[scpr_pkg::CHOP_BIT]);
  // Only A2 matters, and only for a chop; bank and column bits unused
  assign start = (chop && dec_addr[scpr_pkg::ORDER_BIT]) ?
                 scpr_pkg::BEAT_UPPER : scpr_pkg::BEAT_FIRST;
  assign take = (dec_cmd == scpr_pkg::CMD_READ) && s_q.pat_en &&
                (s_q.state == scpr_pkg::ST_IDLE);
  // Reserved locations return zeros rather than array data
  assign pattern = (s_q.loc == scpr_pkg::LOC_PREDEF) ?
                   scpr_pkg::PATTERN_PREDEF : scpr_pkg::PATTERN_RFU;
  assign beat_bit = pattern[s_q.beat];
  assign gen_if.valid = (s_q.state == scpr_pkg::ST_BURST);
  assign gen_if.data = {(s_q.mirror ? {7{beat_bit}} : 7'h00), beat_bit};
  // Pin stage frees its slot when empty or when the receiver takes it
  assign buf_if.ready = !s_q.dqs || dq_ready_in;
  assign wb_req = wb_cyc_in && wb_stb_in && !s_q.ack;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.arr_rd = 1'b0;
    s_d.arr_wr = 1'b0;
    s_d.pre = 1'b0;
    s_d.ack = 1'b0;

    // Commands; in pattern mode only reads and mode-three MRS act, others bar NOP are illegal
    unique case (dec_cmd)
      scpr_pkg::CMD_MRS:
      begin
        if (dec_ba == scpr_pkg::BA_MODE3)
        begin
          s_d.pat_en = dec_addr[scpr_pkg::PAT_EN_BIT];
          s_d.loc = dec_addr[1:0];
        end
        else if (dec_ba == scpr_pkg::BA_MODE0 && !s_q.pat_en)
          s_d.bl_mode = dec_addr[1:0];
        else if (s_q.pat_en)
          s_d.illegal = s_q.illegal + 8'h01;
      end
      scpr_pkg::CMD_READ:
      begin
        if (!s_q.pat_en)
        begin
          s_d.arr_rd = 1'b1;
          s_d.pre = dec_addr[scpr_pkg::AP_BIT];
        end
        else if (s_q.state != scpr_pkg::ST_IDLE)
          s_d.refused = s_q.refused + 8'h01;
      end
      scpr_pkg::CMD_WRITE:
      begin
        if (!s_q.pat_en)
          s_d.arr_wr = 1'b1;
        else
          s_d.illegal = s_q.illegal + 8'h01;
      end
      scpr_pkg::CMD_OTHER:
      begin
        if (s_q.pat_en)
          s_d.illegal = s_q.illegal + 8'h01;
      end
      scpr_pkg::CMD_NONE:
      begin
      end
    endcase

    // Pattern burst: same latency count as array reads, no precharge
    unique case (s_q.state)
      scpr_pkg::ST_IDLE:
      begin
        if (take)
        begin
          s_d.served = s_q.served + 8'h01;
          s_d.lat_cnt = s_q.lat;
          s_d.beat = start;
          s_d.last = chop ? 3'(start + scpr_pkg::CHOP_SPAN) : scpr_pkg::BEAT_LAST;
          s_d.state = scpr_pkg::ST_WAIT;
        end
      end
      scpr_pkg::ST_WAIT:
      begin
        if (s_q.lat_cnt == 4'h0)
          s_d.state = scpr_pkg::ST_BURST;
        else
          s_d.lat_cnt = s_q.lat_cnt - 4'h1;
      end
      scpr_pkg::ST_BURST:
      begin
        // Buffer full stalls the burst, so no beat is dropped
        if (gen_if.ready)
        begin
          if (s_q.beat == s_q.last)
            s_d.state = scpr_pkg::ST_IDLE;
          else
            s_d.beat = 3'(s_q.beat + 3'h1);
        end
      end
    endcase

    // Pin stage
    if (buf_if.ready)
    begin
      s_d.dqs = buf_if.valid;
      s_d.oe_n = !buf_if.valid;
      s_d.dq = buf_if.valid ? buf_if.data : '0;
    end

    // Wishbone slave, answers every address in one cycle
    if (wb_req)
    begin
      s_d.ack = 1'b1;
      unique case (wb_adr_in)
        scpr_pkg::OFS_MODE3: s_d.rdat = {29'h0, s_q.pat_en, s_q.loc};
        scpr_pkg::OFS_MODE0: s_d.rdat = {30'h0, s_q.bl_mode};
        scpr_pkg::OFS_CTRL: s_d.rdat = {27'h0, s_q.mirror, s_q.lat};
        scpr_pkg::OFS_STATUS:
          s_d.rdat = {s_q.illegal, s_q.refused, s_q.served, 6'h0,
                      s_q.state != scpr_pkg::ST_IDLE, s_q.pat_en};
        default: s_d.rdat = 32'h0;
      endcase
      if (wb_we_in && wb_adr_in == scpr_pkg::OFS_CTRL && wb_sel_in[0])
      begin
        s_d.lat = wb_dat_in[3:0];
        s_d.mirror = wb_dat_in[4];
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Reset wins in any mode, pattern mode included
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      s_q <= '0;
      s_q.oe_n <= 1'b1;
      s_q.lat <= scpr_pkg::LAT_RST;
      s_q.mirror <= scpr_pkg::MIRROR_RST;
    end
    else
      s_q <= s_d;
  end

  assign dq_out = s_q.dq;
  assign dq_oe_n_out = s_q.oe_n;
  assign dqs_out = s_q.dqs;
  assign array_rd_out = s_q.arr_rd;
  assign array_wr_out = s_q.arr_wr;
  assign precharge_out = s_q.pre;
  assign wb_dat_out = s_q.rdat;
  assign wb_ack_out = s_q.ack;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence sq_mode3_on;
    dec_cmd == scpr_pkg::CMD_MRS && dec_ba == scpr_pkg::BA_MODE3 &&
    dec_addr[scpr_pkg::PAT_EN_BIT];
  endsequence
  sequence sq_take_upper;
    take && chop && dec_addr[scpr_pkg::ORDER_BIT];
  endsequence
  sequence sq_last_push;
    s_q.state == scpr_pkg::ST_BURST && gen_if.ready && s_q.beat == s_q.last;
  endsequence

  a_mode_enable: assert property (sq_mode3_on |=> s_q.pat_en)
    else $error("pattern mode not entered");
  a_reset_exit: assert property (@(posedge mclk_in) disable iff (1'b0)
    !reset_n_in |=> !s_q.pat_en && s_q.state == scpr_pkg::ST_IDLE && dq_oe_n_out)
    else $error("reset did not clear pattern mode");
  a_no_array_rd: assert property (
    dec_cmd == scpr_pkg::CMD_READ && s_q.pat_en |=> !array_rd_out && !precharge_out)
    else $error("pattern read reached the array");
  a_normal_read: assert property (
    dec_cmd == scpr_pkg::CMD_READ && !s_q.pat_en |=>
    array_rd_out && precharge_out == $past(dec_addr[scpr_pkg::AP_BIT]))
    else $error("array read not forwarded");
  a_pattern_bit: assert property (
    gen_if.valid && s_q.loc == scpr_pkg::LOC_PREDEF |-> gen_if.data[0] == s_q.beat[0])
    else $error("wrong pattern bit");
  a_rfu_zero: assert property (
    gen_if.valid && s_q.loc != scpr_pkg::LOC_PREDEF |-> !gen_if.data[0])
    else $error("reserved location not zero");
  a_pin_copy: assert property (
    dqs_out |-> dq_out[7:1] == 7'h00 || dq_out[7:1] == {7{dq_out[0]}})
    else $error("upper data pins wrong");
  a_bl8_order: assert property (
    take && !chop |=> s_q.beat == scpr_pkg::BEAT_FIRST && s_q.last == scpr_pkg::BEAT_LAST)
    else $error("eight-beat order wrong");
  a_chop_upper: assert property (sq_take_upper |=> s_q.beat == 3'h4 && s_q.last == 3'h7)
    else $error("upper nibble chop wrong");
  a_fixed_bl8: assert property (
    take && s_q.bl_mode == scpr_pkg::BL_FIXED8 |-> !chop)
    else $error("chop taken in fixed eight mode");
  a_lat_count: assert property (
    s_q.state == scpr_pkg::ST_WAIT && s_q.lat_cnt != 4'h0 |=>
    s_q.state == scpr_pkg::ST_WAIT && s_q.lat_cnt == $past(s_q.lat_cnt) - 4'h1)
    else $error("latency count broken");
  a_burst_end: assert property (sq_last_push |=> s_q.state == scpr_pkg::ST_IDLE)
    else $error("burst did not end");
endmodule : scpr_top

// ---- tb/scpr_ctrl_model.sv ----
`timescale 1ns/1ps
// Controller model: issues commands, takes read beats
module scpr_ctrl_model (
  input wire logic mclk_in,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic [2:0] ba_out,
  output logic [13:0] addr_out,
  output logic dq_ready_out,
  input wire logic [7:0] dq_in,
  input wire logic dqs_in
);
  logic [7:0] q[$];
  logic stall = 1'b0;
  int since = 0, nbeat = 0, lat = 0;
  // Deselected at time zero
  initial
  begin
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
    ba_out = 3'h0;
    addr_out = 14'h0;
    dq_ready_out = 1'b1;
  end
  // One command; released pins show inverted noise, not the last value
  task automatic cmd(input logic [3:0] p, input logic [2:0] b, input logic [13:0] a);
    @(posedge mclk_in);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= p;
    ba_out <= b;
    addr_out <= a;
    @(posedge mclk_in);
    cs_n_out <= 1'b1;
    ba_out <= ~b;
    addr_out <= ~a;
  endtask : cmd
  // Stall toggles ready so the buffer must hold beats
  always @(posedge mclk_in)
  begin
    dq_ready_out <= stall ? ~dq_ready_out : 1'b1;
    since <= since + 1;
    nbeat <= nbeat + (dqs_in && dq_ready_out);
    if (!cs_n_out && {ras_n_out, cas_n_out, we_n_out} == 3'h5)
    begin
      since <= 0;
      nbeat <= 0;
    end
    if (dqs_in && dq_ready_out)
    begin
      q.push_back(dq_in);
      if (nbeat == 0)
        lat <= since;
    end
  end
endmodule : scpr_ctrl_model

// ---- tb/sdram_calib_pattern_readout_tb.sv ----
`timescale 1ns/1ps
module sdram_calib_pattern_readout_tb;
  logic mclk_in = 1'b0, reset_n_in = 1'b0;
  logic cs_n, ras_n, cas_n, we_n, rdy, dqs, oe_n, ard, awr, pre, ack;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [7:0] dq;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, d;
  int failures = 0;
  int checked = 0;
  int n_ard = 0, n_awr = 0, n_pre = 0;
  // ------------------------------------------------------------
  // Clock, parties and pulse counters
  // ------------------------------------------------------------
  initial forever #5 mclk_in = ~mclk_in;
  scpr_top dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n), .ras_n_in(ras_n),
    .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba), .addr_in(addr), .dq_ready_in(rdy),
    .dq_out(dq), .dq_oe_n_out(oe_n), .dqs_out(dqs), .array_rd_out(ard), .array_wr_out(awr),
    .precharge_out(pre), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack));
  scpr_ctrl_model ctrl (.mclk_in(mclk_in), .cs_n_out(cs_n), .ras_n_out(ras_n),
    .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba), .addr_out(addr), .dq_ready_out(rdy),
    .dq_in(dq), .dqs_in(dqs));
  always @(posedge mclk_in)
  begin
    n_ard <= n_ard + (ard === 1'b1);
    n_awr <= n_awr + (awr === 1'b1);
    n_pre <= n_pre + (pre === 1'b1);
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk
  // A spent wait counts as a mismatch and ends the run
  task automatic timeout;
    failures++;
    stop_test();
  endtask : timeout
  // Classic cycle held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
    int i;
    @(posedge mclk_in);
    {cyc, stb} <= 2'b11;
    we <= w;
    adr <= a;
    wdat <= v;
    i = 0;
    do
    begin
      @(posedge mclk_in);
      i++;
    end
    while (ack !== 1'b1 && i < 50);
    d = rdat;
    {cyc, stb} <= 2'b00;
    if (i >= 50)
      timeout();
  endtask : wb
  // Register read, compared under a mask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e,
                      input logic [31:0] m);
    wb(1'b0, a, 32'h0);
    chk(nm, e, d & m);
  endtask : rchk
  // Waits for n beats, then idles to catch any extra beat
  task automatic burst(input int n, input logic [7:0] pat, input logic mir, input int first);
    int i;
    i = 0;
    while (ctrl.q.size() < n && i < 200)
    begin
      @(posedge mclk_in);
      i++;
    end
    if (i >= 200)
      timeout();
    repeat (12) @(posedge mclk_in);
    chk("beat count", n, ctrl.q.size());
    for (i = 0; i < n && i < ctrl.q.size(); i++)
      chk("beat", mir ? {24'h0, {8{pat[first + i]}}} : {31'h0, pat[first + i]},
          {24'h0, ctrl.q[i]});
    chk("oe_n idle", 1, oe_n);
    ctrl.q.delete();
  endtask : burst
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    chk("oe_n reset", 1, oe_n);
    rchk("ctrl reset", scpr_pkg::OFS_CTRL, 32'h5, '1);
    rchk("status reset", scpr_pkg::OFS_STATUS, 32'h0, '1);
    rchk("unmapped", 4'h1, 32'h0, '1);
    // Normal mode, also with a location set but the enable clear
    ctrl.cmd(scpr_pkg::PINS_READ, 3'h0, 14'h0400);
    ctrl.cmd(scpr_pkg::PINS_WRITE, 3'h0, 14'h0000);
    ctrl.cmd(scpr_pkg::PINS_MRS, scpr_pkg::BA_MODE3, 14'h0001);
    ctrl.cmd(scpr_pkg::PINS_READ, 3'h0, 14'h0000);
    repeat (3) @(posedge mclk_in);
    chk("array reads", 2, n_ard);
    chk("array writes", 1, n_awr);
    chk("precharges", 1, n_pre);
    chk("no beats", 0, ctrl.q.size());
    ctrl.cmd(scpr_pkg::PINS_MRS, scpr_pkg::BA_MODE0, {12'h0, scpr_pkg::BL_OTF});
    ctrl.cmd(scpr_pkg::PINS_MRS, scpr_pkg::BA_MODE3, 14'h0004);
    rchk("mode three", scpr_pkg::OFS_MODE3, 32'h4, '1);
    rchk("pattern on", scpr_pkg::OFS_STATUS, 32'h1, 32'h1);
    // Full burst; bank, A10 and spare bits set and ignored
    ctrl.cmd(scpr_pkg::PINS_READ, 3'h7, 14'h3ff8);
    burst(8, scpr_pkg::PATTERN_PREDEF, 0, 0);
    chk("latency 5", 9, ctrl.lat);
    chk("no array read", 2, n_ard);
    chk("no precharge", 1, n_pre);
    // Second read while busy is dropped
    ctrl.cmd(scpr_pkg::PINS_READ, 3'h0, 14'h1000);
    ctrl.cmd(scpr_pkg::PINS_READ, 3'h0, 14'h1000);
    burst(8, scpr_pkg::PATTERN_PREDEF, 0, 0);
    rchk("refused", scpr_pkg::OFS_STATUS, 32'h00010000, 32'h00ff0000);
    // Mirrored pins, latency 2, chopped nibbles
    wb(1, scpr_pkg::OFS_CTRL, 32'h12);
    rchk("ctrl rw", scpr_pkg::OFS_CTRL, 32'h12, '1);
    ctrl.cmd(scpr_pkg::PINS_READ, 3'h0, 14'h0000);
    burst(4, scpr_pkg::PATTERN_PREDEF, 1, 0);
    chk("latency 2", 6, ctrl.lat);
    ctrl.cmd(scpr_pkg::PINS_READ, 3'h0, 14'h0004);
    burst(4, scpr_pkg::PATTERN_PREDEF, 1, 4);
    // Receiver stalls on alternate cycles
    ctrl.stall = 1'b1;
    ctrl.cmd(scpr_pkg::PINS_READ, 3'h0, 14'h1000);
    burst(8, scpr_pkg::PATTERN_PREDEF, 1, 0);
    ctrl.stall = 1'b0;
    // Illegal write and mode-zero change while enabled
    ctrl.cmd(scpr_pkg::PINS_WRITE, 3'h0, 14'h0000);
    ctrl.cmd(scpr_pkg::PINS_MRS, scpr_pkg::BA_MODE0, {12'h0, scpr_pkg::BL_FIXED4});
    rchk("illegal", scpr_pkg::OFS_STATUS, 32'h02000000, 32'hff000000);
    chk("write blocked", 1, n_awr);
    rchk("mode zero kept", scpr_pkg::OFS_MODE0, 32'h1, '1);
    // Reserved location gives zero beats
    ctrl.cmd(scpr_pkg::PINS_MRS, scpr_pkg::BA_MODE3, 14'h0005);
    ctrl.cmd(scpr_pkg::PINS_READ, 3'h0, 14'h1000);
    burst(8, scpr_pkg::PATTERN_RFU, 1, 0);
    // Reset in pattern mode
    reset_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    rchk("status after reset", scpr_pkg::OFS_STATUS, 32'h0, '1);
    // Fixed chop overrides A12
    ctrl.cmd(scpr_pkg::PINS_MRS, scpr_pkg::BA_MODE0, {12'h0, scpr_pkg::BL_FIXED4});
    ctrl.cmd(scpr_pkg::PINS_MRS, scpr_pkg::BA_MODE3, 14'h0004);
    ctrl.cmd(scpr_pkg::PINS_READ, 3'h0, 14'h1000);
    burst(4, scpr_pkg::PATTERN_PREDEF, 0, 0);
    // Disable returns reads to the array; two normal reads came before
    ctrl.cmd(scpr_pkg::PINS_MRS, scpr_pkg::BA_MODE3, 14'h0000);
    ctrl.cmd(scpr_pkg::PINS_READ, 3'h0, 14'h0000);
    repeat (3) @(posedge mclk_in);
    chk("array read back", 3, n_ard);
    rchk("pattern off", scpr_pkg::OFS_STATUS, 32'h0, 32'h1);
    stop_test();
  end
endmodule : sdram_calib_pattern_readout_tb
